/* shared/gate_pkg.sv */
// constants and types shared by the boolean gate blocks
package gate_pkg;

	// ----------------------------------------
	// input shape
	// ----------------------------------------
	localparam int INPUT_COUNT = 4;
	typedef logic [INPUT_COUNT-1:0] gateIn_t;

	// ----------------------------------------
	// levels given to unused inputs
	// ----------------------------------------
	localparam logic UNUSED_AND_LEVEL = 1'b1;
	localparam logic UNUSED_OR_LEVEL = 1'b0;

	// ----------------------------------------
	// reset values and all-low/all-high input patterns
	// ----------------------------------------
	localparam logic OUT_RESET = 1'b0;
	localparam gateIn_t PREV_RESET = 4'h0;
	localparam gateIn_t ALL_LOW = 4'h0;
	localparam gateIn_t ALL_HIGH = 4'hf;

endpackage : gate_pkg

/* rtl/boolean_gate_blocks.sv */
// four-input and, nand, or, nor and edge-evaluated and/nand gates, one step per program cycle
//
// Notes on behaviour
// R1 - the and output is high only when all four conditioned inputs are high.
// R2 - the edge and pulses when all inputs are high now and at least one was low last cycle.
// R3 - the edge and pulse lasts one program cycle and is low the next before it can return.
// R4 - the nand output is low only when all four conditioned inputs are high.
// R5 - the edge nand pulses when at least one input is low now and all were high last cycle.
// R6 - the edge nand pulse lasts one program cycle and is low at least the next cycle.
// R7 - the or output is high when any conditioned input is high.
// R8 - the nor output is high only while all conditioned inputs are low.
// R9 - unused inputs of the and, nand and both edge gates read as a constant high.
// R10 - unused inputs of the or and nor gates read as a constant low.
// R11 - each used input can be inverted so the gate sees the complement of its signal.
// R12 - gates step only on the program-cycle strobe, and edge history clears on reset.
`timescale 1ns/10ps

module boolean_gate_blocks (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic cycleStrobe,
	input wire gate_pkg::gateIn_t andIn,
	input wire gate_pkg::gateIn_t andUsed,
	input wire gate_pkg::gateIn_t andInvert,
	input wire gate_pkg::gateIn_t nandIn,
	input wire gate_pkg::gateIn_t nandUsed,
	input wire gate_pkg::gateIn_t nandInvert,
	input wire gate_pkg::gateIn_t orIn,
	input wire gate_pkg::gateIn_t orUsed,
	input wire gate_pkg::gateIn_t orInvert,
	input wire gate_pkg::gateIn_t norIn,
	input wire gate_pkg::gateIn_t norUsed,
	input wire gate_pkg::gateIn_t norInvert,
	input wire gate_pkg::gateIn_t edgeAndIn,
	input wire gate_pkg::gateIn_t edgeAndUsed,
	input wire gate_pkg::gateIn_t edgeAndInvert,
	input wire gate_pkg::gateIn_t edgeNandIn,
	input wire gate_pkg::gateIn_t edgeNandUsed,
	input wire gate_pkg::gateIn_t edgeNandInvert,
	output logic andOut,
	output logic nandOut,
	output logic orOut,
	output logic norOut,
	output logic edgeAndOut,
	output logic edgeNandOut
);

	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	// inversion applies only to a used input; an unused one takes the fixed level as is
	function automatic gate_pkg::gateIn_t condition(
		input gate_pkg::gateIn_t sig,
		input gate_pkg::gateIn_t used,
		input gate_pkg::gateIn_t invert,
		input logic unusedLevel
	);
		gate_pkg::gateIn_t res;
		res = gate_pkg::ALL_LOW;
		for (int i = 0; i < gate_pkg::INPUT_COUNT; i++) begin
			if (used[i]) begin
				res[i] = sig[i] ^ invert[i]; // R11
			end else begin
				res[i] = unusedLevel; // R9 R10
			end
		end
		return res;
	endfunction : condition

	wire gate_pkg::gateIn_t andEff;
	wire gate_pkg::gateIn_t nandEff;
	wire gate_pkg::gateIn_t orEff;
	wire gate_pkg::gateIn_t norEff;
	wire gate_pkg::gateIn_t edgeAndEff;
	wire gate_pkg::gateIn_t edgeNandEff;

	assign andEff = condition(andIn, andUsed, andInvert, gate_pkg::UNUSED_AND_LEVEL); // R9
	assign nandEff = condition(nandIn, nandUsed, nandInvert, gate_pkg::UNUSED_AND_LEVEL); // R9
	assign orEff = condition(orIn, orUsed, orInvert, gate_pkg::UNUSED_OR_LEVEL); // R10
	assign norEff = condition(norIn, norUsed, norInvert, gate_pkg::UNUSED_OR_LEVEL); // R10
	assign edgeAndEff = condition(edgeAndIn, edgeAndUsed, edgeAndInvert,
		gate_pkg::UNUSED_AND_LEVEL); // R9
	assign edgeNandEff = condition(edgeNandIn, edgeNandUsed, edgeNandInvert,
		gate_pkg::UNUSED_AND_LEVEL); // R9

	// ----------------------------------------
	// gate functions
	// ----------------------------------------
	wire logic next_andOut;
	wire logic next_nandOut;
	wire logic next_orOut;
	wire logic next_norOut;
	wire logic next_edgeAndOut;
	wire logic next_edgeNandOut;

	// edge history holds the conditioned inputs seen at the previous strobe
	gate_pkg::gateIn_t edgeAndPrev;
	gate_pkg::gateIn_t edgeNandPrev;

	assign next_andOut = (andEff == gate_pkg::ALL_HIGH); // R1
	assign next_nandOut = (nandEff != gate_pkg::ALL_HIGH); // R4
	assign next_orOut = (orEff != gate_pkg::ALL_LOW); // R7
	assign next_norOut = (norEff == gate_pkg::ALL_LOW); // R8
	// a held condition cannot retrigger, since the history then matches the present inputs
	assign next_edgeAndOut = (edgeAndEff == gate_pkg::ALL_HIGH)
		&& (edgeAndPrev != gate_pkg::ALL_HIGH); // R2 R3
	assign next_edgeNandOut = (edgeNandEff != gate_pkg::ALL_HIGH)
		&& (edgeNandPrev == gate_pkg::ALL_HIGH); // R5 R6

	// ----------------------------------------
	// output and history registers
	// ----------------------------------------
	// outputs hold between strobes, so a pulse lasts exactly one program cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			andOut <= gate_pkg::OUT_RESET;
			nandOut <= gate_pkg::OUT_RESET;
			orOut <= gate_pkg::OUT_RESET;
			norOut <= gate_pkg::OUT_RESET;
			edgeAndOut <= gate_pkg::OUT_RESET;
			edgeNandOut <= gate_pkg::OUT_RESET;
		end else if (cycleStrobe) begin
			andOut <= next_andOut; // R12
			nandOut <= next_nandOut; // R12
			orOut <= next_orOut; // R12
			norOut <= next_norOut; // R12
			edgeAndOut <= next_edgeAndOut; // R12
			edgeNandOut <= next_edgeNandOut; // R12
		end
	end

	// cleared history makes an all-high first cycle look like an edge, as after power loss
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			edgeAndPrev <= gate_pkg::PREV_RESET; // R12
			edgeNandPrev <= gate_pkg::PREV_RESET; // R12
		end else if (cycleStrobe) begin
			edgeAndPrev <= edgeAndEff; // R12
			edgeNandPrev <= edgeNandEff; // R12
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_and_all_high: assert property ( // R1
		cycleStrobe |=> andOut == ($past(andEff) == gate_pkg::ALL_HIGH))
		else $error("and output does not follow its inputs");

	chk_edge_and_rise: assert property ( // R2
		cycleStrobe && edgeAndEff == gate_pkg::ALL_HIGH && edgeAndPrev != gate_pkg::ALL_HIGH
		|=> edgeAndOut)
		else $error("edge and missed a rising condition");

	chk_edge_and_only: assert property ( // R2
		cycleStrobe |=> edgeAndOut == ($past(edgeAndEff) == gate_pkg::ALL_HIGH
			&& $past(edgeAndPrev) != gate_pkg::ALL_HIGH))
		else $error("edge and pulsed without a rising condition");

	// the strobe after a pulse sees an all-high history, so it must clear the pulse
	chk_edge_and_single: assert property ( // R3
		cycleStrobe && edgeAndOut |=> !edgeAndOut)
		else $error("edge and pulse longer than one program cycle");

	chk_nand_low_all: assert property ( // R4
		cycleStrobe && nandEff == gate_pkg::ALL_HIGH |=> !nandOut)
		else $error("nand not low with all inputs high");

	chk_nand_follow: assert property ( // R4
		cycleStrobe |=> nandOut == ($past(nandEff) != gate_pkg::ALL_HIGH))
		else $error("nand output does not follow its inputs");

	chk_edge_nand_fall: assert property ( // R5
		cycleStrobe |=> edgeNandOut == ($past(edgeNandEff) != gate_pkg::ALL_HIGH
			&& $past(edgeNandPrev) == gate_pkg::ALL_HIGH))
		else $error("edge nand output wrong");

	chk_edge_nand_gap: assert property ( // R6
		edgeNandOut && !$past(edgeNandOut) |-> !next_edgeNandOut)
		else $error("edge nand can retrigger back to back");

	chk_edge_nand_single: assert property ( // R6
		cycleStrobe && edgeNandOut |=> !edgeNandOut)
		else $error("edge nand pulse longer than one program cycle");

	chk_or_any_high: assert property ( // R7
		cycleStrobe |=> orOut == ($past(orEff) != gate_pkg::ALL_LOW))
		else $error("or output does not follow its inputs");

	chk_nor_all_low: assert property ( // R8
		cycleStrobe |=> norOut == ($past(norEff) == gate_pkg::ALL_LOW))
		else $error("nor output does not follow its inputs");

	chk_unused_and_high: assert property ( // R9
		andUsed == gate_pkg::ALL_LOW |-> andEff == gate_pkg::ALL_HIGH)
		else $error("unused and input not high");

	chk_unused_nand_high: assert property ( // R9
		nandUsed == gate_pkg::ALL_LOW |-> nandEff == gate_pkg::ALL_HIGH)
		else $error("unused nand input not high");

	chk_unused_edge_high: assert property ( // R9
		edgeAndUsed == gate_pkg::ALL_LOW && edgeNandUsed == gate_pkg::ALL_LOW
		|-> edgeAndEff == gate_pkg::ALL_HIGH && edgeNandEff == gate_pkg::ALL_HIGH)
		else $error("unused edge gate input not high");

	chk_unused_or_low: assert property ( // R10
		orUsed == gate_pkg::ALL_LOW |-> orEff == gate_pkg::ALL_LOW)
		else $error("unused or input not low");

	chk_unused_nor_low: assert property ( // R10
		norUsed == gate_pkg::ALL_LOW |-> norEff == gate_pkg::ALL_LOW)
		else $error("unused nor input not low");

	chk_invert_used: assert property ( // R11
		andUsed == gate_pkg::ALL_HIGH |-> andEff == (andIn ^ andInvert))
		else $error("inversion not applied");

	chk_invert_or: assert property ( // R11
		orUsed == gate_pkg::ALL_HIGH |-> orEff == (orIn ^ orInvert))
		else $error("or inversion not applied");

	chk_hold_between: assert property ( // R12
		!cycleStrobe |=> $stable(andOut) && $stable(edgeAndOut) && $stable(edgeAndPrev))
		else $error("state changed without a strobe");

	chk_hold_others: assert property ( // R12
		!cycleStrobe |=> $stable(nandOut) && $stable(orOut) && $stable(norOut)
			&& $stable(edgeNandOut) && $stable(edgeNandPrev))
		else $error("output changed without a strobe");

	chk_history_load: assert property ( // R12
		cycleStrobe |=> edgeAndPrev == $past(edgeAndEff) && edgeNandPrev == $past(edgeNandEff))
		else $error("edge history not taken on the strobe");

	cov_edge_and_pulse: cover property (cycleStrobe && next_edgeAndOut ##1 edgeAndOut);
	cov_edge_nand_pulse: cover property (cycleStrobe && next_edgeNandOut ##1 edgeNandOut);
	cov_nor_high: cover property (norOut ##1 !norOut);
	cov_inverted_and: cover property (cycleStrobe && andInvert != 4'h0 && next_andOut);

endmodule : boolean_gate_blocks

/* tb/gate_source.sv */
// partner model: upstream function blocks feeding the gate inputs
`timescale 1ns/10ps

module gate_source (
	input wire logic core_clk,
	output gate_pkg::gateIn_t sig,
	output gate_pkg::gateIn_t used,
	output gate_pkg::gateIn_t inv
);
	// ----------------------------------------
	// source levels
	// ----------------------------------------
	// upstream blocks only change after a falling edge, so the strobe edge never races them
	initial begin
		sig = gate_pkg::ALL_LOW;
		used = gate_pkg::ALL_LOW;
		inv = gate_pkg::ALL_LOW;
	end

	task automatic apply(input logic [11:0] row);
		@(negedge core_clk);
		{sig, used, inv} = row;
	endtask : apply
endmodule : gate_source

/* tb/tb_boolean_gate_blocks.sv */
// self-checking bench for the boolean gate blocks
`timescale 1ns/10ps

module tb_boolean_gate_blocks;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic cycleStrobe = 1'b0;
	gate_pkg::gateIn_t sig, used, inv;
	wire logic [5:0] outs;
	logic [5:0] exp;
	int failures = 0;
	int checked = 0;
	// rows are {signal, used, invert, expected and/nand/or/nor/edge and/edge nand}
	// order matters: edge gates see the previous row
	localparam logic [17:0] ROWS [11] = '{{12'hff0, 6'h2a}, {12'hff0, 6'h28}, {12'hef0, 6'h19},
		{12'hef0, 6'h18}, {12'h0f0, 6'h14}, {12'h0ff, 6'h2a}, {12'h000, 6'h24}, {12'h110, 6'h28},
		{12'h00f, 6'h24}, {12'h8f0, 6'h19}, {12'hff0, 6'h2a}};

	always #2 core_clk = ~core_clk;

	gate_source gate_source_i (.core_clk(core_clk), .sig(sig), .used(used), .inv(inv));

	boolean_gate_blocks boolean_gate_blocks_i (.core_clk(core_clk), .nrst(nrst),
		.cycleStrobe(cycleStrobe), .andIn(sig), .andUsed(used), .andInvert(inv),
		.nandIn(sig), .nandUsed(used), .nandInvert(inv), .orIn(sig), .orUsed(used),
		.orInvert(inv), .norIn(sig), .norUsed(used), .norInvert(inv), .edgeAndIn(sig),
		.edgeAndUsed(used), .edgeAndInvert(inv), .edgeNandIn(sig), .edgeNandUsed(used),
		.edgeNandInvert(inv), .andOut(outs[5]), .nandOut(outs[4]), .orOut(outs[3]),
		.norOut(outs[2]), .edgeAndOut(outs[1]), .edgeNandOut(outs[0]));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [5:0] seen, input logic [5:0] want);
		checked++;
		if (seen !== want) begin
			failures++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
		end
	endtask : check

	task automatic step(input logic [11:0] row);
		gate_source_i.apply(row);
		cycleStrobe = 1'b1;
		@(negedge core_clk);
		cycleStrobe = 1'b0;
	endtask : step

	task automatic test_done();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge core_clk);
		check(outs, 6'h00);
		nrst = 1'b1;
		$display("reset test done");
		foreach (ROWS[i]) begin
			step(ROWS[i][17:6]);
			exp = ROWS[i][5:0];
			check(outs, exp);
		end
		$display("table test done");
		// inputs move but no strobe comes: every output must hold
		gate_source_i.apply(12'h000);
		repeat (3) @(negedge core_clk);
		check(outs, exp);
		$display("no strobe test done");
		nrst = 1'b0;
		@(negedge core_clk);
		nrst = 1'b1;
		check(outs, 6'h00);
		// strobe held for two edges: history cleared, so one pulse then low
		gate_source_i.apply(12'hff0);
		cycleStrobe = 1'b1;
		@(negedge core_clk);
		check(outs, 6'h2a);
		@(negedge core_clk);
		cycleStrobe = 1'b0;
		check(outs, 6'h28);
		$display("mid reset test done");
		test_done();
	end

	// cut a hang short: the tests need well under 200 cycles
	initial begin
		repeat (1000) @(posedge core_clk);
		failures++;
		test_done();
	end
endmodule : tb_boolean_gate_blocks
